/* logic/acs_pkg.sv */
// Shared constants and types for the conversion sequencer and its serial read-out.
package acs_pkg;

  // ------------------------------------------------------------------
  // Word format
  // ------------------------------------------------------------------
  localparam int ACS_WORD_W = 24;

  // ------------------------------------------------------------------
  // Conversion timing, in master-clock cycles
  // ------------------------------------------------------------------
  localparam int             ACS_CNT_W     = 12;
  localparam logic [11:0]    ACS_DELAY_CYC = 12'h49E;  // Wait before the modulator runs.
  localparam logic [11:0]    ACS_ACT_CYC   = 12'h162;  // High-power modulator phase.
  localparam logic [11:0]    ACS_QUIET_CYC = 12'h040;  // Low-power phase before ready.
  localparam logic [11:0]    ACS_GRP_DLY   = 12'h0A0;  // Filter group delay into active phase.
  localparam logic [11:0]    ACS_WAKE_CYC  = 12'hC0B;  // Recovery after power-down release.
  localparam logic [11:0]    ACS_RDY_EARLY = 12'h002;  // Early ready release when unread.
  localparam logic [11:0]    ACS_CONV_CYC  = 12'h640;  // Back-to-back conversion period.

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ACS_IDLE,
    ACS_WAIT,
    ACS_ACTIVE,
    ACS_QUIET,
    ACS_SLEEP,
    ACS_WAKE
  } acs_state_t;

endpackage

/* logic/acs_link_shift.sv */
// Serial-clock domain shifter for the host-clocked read-out mode.
`timescale 1ns/1ps
module acs_link_shift
#(
  parameter int WORD_W = acs_pkg::ACS_WORD_W
)
(
  input  wire logic              link_sclk,      // Serial clock from the host
  input  wire logic              rstn,           // Asynchronous reset, active low
  input  wire logic              chip_select_n,  // Chip select pin, active low
  input  wire logic [WORD_W-1:0] word,           // Result word, stable while ready is low
  output logic                   serial_bit,     // Current output bit
  output logic                   done_toggle     // Flips once per completed word
);
  import acs_pkg::*;

  localparam int CW = $clog2(WORD_W + 1);

  logic [CW-1:0] cnt_q;
  logic          tgl_q;
  wire           frame_rst_n = rstn & ~chip_select_n;
  wire  [CW-1:0] bit_idx     = CW'(WORD_W - 1) - cnt_q;
  wire           in_word     = cnt_q < CW'(WORD_W);
  wire           last_fall   = cnt_q == CW'(WORD_W - 1);

  // ------------------------------------------------------------------
  // Bit counter
  // ------------------------------------------------------------------
  // Chip select high clears the frame without needing a clock edge,
  // because the host clock may stand still between frames.
  always_ff @(negedge link_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      cnt_q <= '0;
    else if (in_word)
      cnt_q <= cnt_q + CW'(1);
  end

  // ------------------------------------------------------------------
  // Completion event
  // ------------------------------------------------------------------
  // The toggle is kept out of the frame reset so that a chip select
  // rising right after the last edge cannot swallow the event.
  always_ff @(negedge link_sclk or negedge rstn)
  begin
    if (!rstn)
      tgl_q <= 1'b0;
    else if (last_fall)
      tgl_q <= ~tgl_q;
  end

  // Bits advance on the falling edge, after the host sampled on the rising one.
  assign serial_bit  = in_word ? word[bit_idx] : 1'b0;
  assign done_toggle = tgl_q;

endmodule

/* logic/acs_sequencer.sv */
// Conversion sequencer with result coding and serial read-out of a delta-sigma converter.
//
// Behaviour
// - Start pin low begins a conversion sequence.
// - Start held low converts every 1600 cycles.
// - Ready tied to start gives 1602 cycles.
// - Asynchronous start slips up to four cycles.
// - Result loaded into port, then ready low.
// - Ready released after whole word shifted out.
// - Unread word, chip select low: ready high two cycles early.
// - Each new conversion overwrites port, ready low.
// - Power-down low stops all conversions.
// - Wake takes 3083 cycles, then ready low.
// - Polarity select picks the output coding.
// - Role select low: host-clocked slave port.
// - Data line driven only with chip select low.
// - Data changes only after serial falling edge.
// - Slave: ready rises after last falling edge.
// - Filter group delay 160 cycles, inside active.
// - Every delivered result is 24 bits.
// - Role select high: master clock at half rate.
// - Low offset binary, high two's complement.
// - Active phase 354 cycles, quiet phase 64.
`timescale 1ns/1ps
module acs_sequencer
#(
  parameter int WORD_W = acs_pkg::ACS_WORD_W
)
(
  input  wire logic              core_clk,          // Master clock
  input  wire logic              rstn,              // Asynchronous reset, active low
  input  wire logic              start_convert_n,   // Conversion start pin, active low
  input  wire logic              power_down_n,      // Low-power request pin, active low
  input  wire logic              polarity_select,   // 1: two's complement, 0: offset binary
  input  wire logic              port_role_select,  // 1: master-clocked, 0: host-clocked
  input  wire logic              chip_select_n,     // Serial port select, active low
  input  wire logic              link_sclk_in,      // Serial clock pin, input side
  input  wire logic [WORD_W-1:0] analog_code,       // Offset-binary modulator result
  output logic                   data_ready_n,      // Result ready, active low
  output logic                   serial_out_line,   // Serial data pin, output side
  output logic                   serial_out_oe,     // Serial data pin enable
  output logic                   sclk_out,          // Serial clock pin, output side
  output logic                   sclk_out_oe,       // Serial clock pin enable
  output logic                   modulator_active   // High during the active phase
);
  import acs_pkg::*;

  localparam int                MW        = $clog2(WORD_W + 1);
  localparam logic [WORD_W-1:0] SIGN_FLIP = {1'b1, {(WORD_W - 1){1'b0}}};

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (WORD_W < 2 || WORD_W > 32)
  begin : g_bad_width
    $error("acs_sequencer: WORD_W must lie between 2 and 32");
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Bit order: start, power-down, polarity, role, chip select.
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [1:0] tgl_meta_q;
  logic       tgl_sync_q;
  logic       tgl_seen_q;
  wire        link_toggle;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= 5'h1B;
      sync_q <= 5'h1B;
    end
    else
    begin
      meta_q <= {start_convert_n, power_down_n, polarity_select,
                 port_role_select, chip_select_n};
      sync_q <= meta_q;
    end
  end

  // Completion event from the serial-clock domain, carried as a toggle.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tgl_meta_q <= 2'h0;
      tgl_sync_q <= 1'b0;
      tgl_seen_q <= 1'b0;
    end
    else
    begin
      tgl_meta_q <= {tgl_meta_q[0], link_toggle};
      tgl_sync_q <= tgl_meta_q[1];
      tgl_seen_q <= tgl_sync_q;
    end
  end

  wire start_low  = ~sync_q[4];
  wire pd_active  = ~sync_q[3];
  wire pol_twos   = sync_q[2];
  wire role_mast  = sync_q[1];
  wire cs_low     = ~sync_q[0];
  wire slave_done = (tgl_sync_q ^ tgl_seen_q) & ~role_mast;

  // ------------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------------
  acs_state_t           state_q;
  acs_state_t           state_d;
  logic [ACS_CNT_W-1:0] cnt_q;
  logic [ACS_CNT_W-1:0] cnt_d;

  wire wait_end   = cnt_q == ACS_DELAY_CYC - 12'h001;
  wire act_end    = cnt_q == ACS_ACT_CYC - 12'h001;
  wire quiet_end  = cnt_q == ACS_QUIET_CYC - 12'h001;
  wire wake_end   = cnt_q == ACS_WAKE_CYC - 12'h001;
  wire conv_done  = (state_q == ACS_QUIET) && quiet_end && !pd_active;
  wire wake_done  = (state_q == ACS_WAKE) && wake_end && !pd_active;
  wire grp_sample = (state_q == ACS_ACTIVE) && (cnt_q == ACS_GRP_DLY);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q + 12'h001;
    unique case (state_q)
      ACS_IDLE:
      begin
        // Entering one count in absorbs the start synchroniser's latency.
        cnt_d = start_low ? 12'h001 : 12'h000;
        if (start_low)
          state_d = ACS_WAIT;
      end
      ACS_WAIT:
      begin
        if (wait_end)
        begin
          state_d = ACS_ACTIVE;
          cnt_d   = '0;
        end
      end
      ACS_ACTIVE:
      begin
        if (act_end)
        begin
          state_d = ACS_QUIET;
          cnt_d   = '0;
        end
      end
      ACS_QUIET:
      begin
        if (quiet_end)
        begin
          // Start still low chains the next conversion with no gap.
          state_d = start_low ? ACS_WAIT : ACS_IDLE;
          cnt_d   = '0;
        end
      end
      ACS_SLEEP:
      begin
        cnt_d = '0;
        if (!pd_active)
          state_d = ACS_WAKE;
      end
      ACS_WAKE:
      begin
        if (wake_end)
        begin
          state_d = ACS_IDLE;
          cnt_d   = '0;
        end
      end
    endcase
    if (pd_active)
    begin
      state_d = ACS_SLEEP;
      cnt_d   = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ACS_IDLE;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ------------------------------------------------------------------
  // Result capture and coding
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] sample_q;
  logic [WORD_W-1:0] word_q;
  wire  [WORD_W-1:0] coded = pol_twos ? (sample_q ^ SIGN_FLIP) : sample_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sample_q <= '0;
      word_q   <= '0;
    end
    else
    begin
      if (grp_sample)
        sample_q <= analog_code;
      if (conv_done)
        word_q <= coded;
    end
  end

  // ------------------------------------------------------------------
  // Master-clocked read-out
  // ------------------------------------------------------------------
  logic          sclk_q;
  logic [MW-1:0] mcnt_q;
  logic          sdo_q;
  wire           m_run   = role_mast & cs_low & ~data_ready_n & (mcnt_q < MW'(WORD_W));
  wire           m_fall  = m_run & sclk_q;
  wire           m_last  = m_fall & (mcnt_q == MW'(WORD_W - 1));
  wire  [MW-1:0] mcnt_d  = conv_done ? '0 : (m_fall ? mcnt_q + MW'(1) : mcnt_q);
  wire  [MW-1:0] m_idx   = MW'(WORD_W - 1) - mcnt_d;
  wire  [WORD_W-1:0] sdo_src = conv_done ? coded : word_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_q <= 1'b0;
      mcnt_q <= '0;
      sdo_q  <= 1'b0;
    end
    else
    begin
      sclk_q <= m_run & ~sclk_q;
      mcnt_q <= mcnt_d;
      sdo_q  <= (mcnt_d < MW'(WORD_W)) ? sdo_src[m_idx] : 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Host-clocked read-out
  // ------------------------------------------------------------------
  // The word is held still while ready is low, so the shifter may read
  // it across domains; a read overlapping a result load is not safe.
  logic slave_bit;

  acs_link_shift #(.WORD_W(WORD_W)) u_link
  (
    .link_sclk     (link_sclk_in),
    .rstn          (rstn),
    .chip_select_n (chip_select_n),
    .word          (word_q),
    .serial_bit    (slave_bit),
    .done_toggle   (link_toggle)
  );

  // ------------------------------------------------------------------
  // Ready flag
  // ------------------------------------------------------------------
  logic rdy_n_q;
  wire  read_done  = m_last | slave_done;
  wire  early_rel  = (state_q == ACS_QUIET) && !rdy_n_q && cs_low &&
                     (cnt_q == ACS_QUIET_CYC - 12'h001 - ACS_RDY_EARLY);

  // A new result wins over a release in the same cycle.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdy_n_q <= 1'b1;
    else if (pd_active)
      rdy_n_q <= 1'b1;
    else if (conv_done || wake_done)
      rdy_n_q <= 1'b0;
    else if (read_done || early_rel)
      rdy_n_q <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  assign data_ready_n     = rdy_n_q;
  assign serial_out_line  = role_mast ? sdo_q : slave_bit;
  assign serial_out_oe    = ~chip_select_n;
  assign sclk_out         = sclk_q;
  assign sclk_out_oe      = role_mast & ~chip_select_n;
  assign modulator_active = state_q == ACS_ACTIVE;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  logic [ACS_CNT_W-1:0] gap_q;
  logic                 cont_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_q  <= '0;
      cont_q <= 1'b0;
    end
    else
    begin
      gap_q  <= conv_done ? '0 : gap_q + {11'h000, gap_q != '1};
      cont_q <= conv_done ? start_low : (cont_q & start_low & ~pd_active);
    end
  end

  start_seq_a: assert property
    (state_q == ACS_IDLE && start_low && !pd_active |=> state_q == ACS_WAIT)
    else $error("start low in idle did not begin a conversion");

  conv_period_a: assert property
    (conv_done && cont_q |-> gap_q == ACS_CONV_CYC - 12'h001)
    else $error("continuous conversion period is wrong");

  phase_len_a: assert property
    (state_q == ACS_ACTIVE && act_end && !pd_active |=>
       state_q == ACS_QUIET && cnt_q == '0)
    else $error("active phase length is wrong");

  load_ready_a: assert property
    (conv_done |=> !data_ready_n && word_q == $past(coded))
    else $error("result not loaded with ready low");

  coding_a: assert property
    (conv_done && pol_twos |=> word_q == ($past(sample_q) ^ SIGN_FLIP))
    else $error("two's complement coding wrong");

  group_dly_a: assert property
    (grp_sample |=> sample_q == $past(analog_code) && state_q == ACS_ACTIVE)
    else $error("sample not taken at group delay");

  early_rel_a: assert property
    (early_rel && !pd_active |=> data_ready_n ##2 !data_ready_n)
    else $error("unread ready not released two cycles early");

  sleep_a: assert property
    (pd_active |=> state_q == ACS_SLEEP && data_ready_n [*1])
    else $error("power-down did not stop conversions");

  wake_a: assert property
    (wake_done |=> !data_ready_n && state_q == ACS_IDLE)
    else $error("ready not dropped after wake");

  master_clk_a: assert property
    (m_run && !conv_done |=> sclk_q != $past(sclk_q))
    else $error("master serial clock not at half rate");

  master_done_a: assert property
    (m_last && !conv_done && !pd_active |=> data_ready_n)
    else $error("ready not released after last master bit");

  slave_done_a: assert property
    (slave_done && !conv_done && !wake_done |=> data_ready_n)
    else $error("ready not released after host read");

  tri_state_a: assert property
    (chip_select_n |-> !serial_out_oe && !sclk_out_oe)
    else $error("pins driven with chip select high");

  continuous_c: cover property (conv_done && cont_q);
  master_read_c: cover property (m_last);
  slave_read_c: cover property (slave_done && !data_ready_n);
  wake_c: cover property (wake_done);

endmodule

/* verification/acs_host_model.sv */
// Host controller model that reads result words over the host-clocked port.
`timescale 1ns/1ps
module acs_host_model
(
  input  wire logic        read_go,        // Rising edge starts one word read
  input  wire logic        hold_sel,       // Keeps chip select low with no clocks
  input  wire logic        serial_in,      // Serial data line as seen at the pin
  output logic             chip_select_n,  // Chip select, active low
  output logic             link_sclk,      // Serial clock, still between frames
  output logic [23:0]      word,           // Last word captured
  output logic             done            // Pulses once a word is captured
);
  logic busy;

  assign chip_select_n = ~(busy | hold_sel);

  // ------------------------------------------------------------------
  // Read frame
  // ------------------------------------------------------------------
  // The 3 ns offset keeps the link clock out of phase with the core clock.
  initial
  begin
    busy = 1'b0;
    link_sclk = 1'b0;
    word = 24'h000000;
    done = 1'b0;
    forever
    begin
      @(posedge read_go);
      busy = 1'b1;
      #103;
      for (int i = 0; i < 24; i++)
      begin
        link_sclk = 1'b1;
        word = {word[22:0], serial_in};
        #40;
        link_sclk = 1'b0;
        #40;
      end
      #100;
      busy = 1'b0;
      done = 1'b1;
      #20;
      done = 1'b0;
    end
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the conversion sequencer and its serial read-out.
`timescale 1ns/1ps
module testbench;
  logic        core_clk;
  logic        rstn;
  logic        start_q;
  logic        tie;
  logic        power_down_n;
  logic        polarity_select;
  logic        port_role_select;
  logic [23:0] analog_code;
  logic        hold_sel;
  logic        read_go;
  wire         chip_select_n;
  wire         link_sclk;
  wire  [23:0] host_word;
  wire         host_done;
  logic        data_ready_n;
  logic        serial_out_line;
  logic        serial_out_oe;
  logic        sclk_out;
  logic        sclk_out_oe;
  logic        modulator_active;
  wire         start_pin;
  wire         sdo_wire;
  logic [23:0] got_word;
  logic [23:0] m_shift;
  logic [23:0] codes [4] = '{24'h000000, 24'hFFFFFF, 24'h800000, 24'h7FFFFF};
  logic [23:0] expq [$];
  int          m_cnt;
  int          act_n;
  int          fails;
  int          n_checks;
  int          n;
  int          t;
  int          seed;
  event        got;

  // Ready fed back to start is modelled with a kick input from the bench.
  assign start_pin = tie ? (start_q & data_ready_n) : start_q;
  // The data line has a pull-down while nobody drives it.
  assign sdo_wire = serial_out_oe ? serial_out_line : 1'b0;

  acs_sequencer uut
  (
    .core_clk         (core_clk),
    .rstn             (rstn),
    .start_convert_n  (start_pin),
    .power_down_n     (power_down_n),
    .polarity_select  (polarity_select),
    .port_role_select (port_role_select),
    .chip_select_n    (chip_select_n),
    .link_sclk_in     (link_sclk),
    .analog_code      (analog_code),
    .data_ready_n     (data_ready_n),
    .serial_out_line  (serial_out_line),
    .serial_out_oe    (serial_out_oe),
    .sclk_out         (sclk_out),
    .sclk_out_oe      (sclk_out_oe),
    .modulator_active (modulator_active)
  );

  acs_host_model host
  (
    .read_go       (read_go),
    .hold_sel      (hold_sel),
    .serial_in     (sdo_wire),
    .chip_select_n (chip_select_n),
    .link_sclk     (link_sclk),
    .word          (host_word),
    .done          (host_done)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic give_verdict;
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  task automatic wait_rdy(input logic lvl, input int lim);
    n = 0;
    while (data_ready_n !== lvl)
    begin
      @(negedge core_clk);
      n++;
      if (n > lim)
      begin
        fails++;
        $display("mismatch at %0t: ready wait ran out", $time);
        give_verdict;
      end
    end
  endtask

  task automatic do_reset;
    rstn = 1'b0;
    cyc(10);
    rstn = 1'b1;
    cyc(3);
    check(data_ready_n, 1'b1);
  endtask

  // ------------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------------
  always @(posedge sclk_out)
  begin
    m_shift = {m_shift[22:0], sdo_wire};
    m_cnt++;
    if (m_cnt == 24)
    begin
      m_cnt = 0;
      got_word = m_shift;
      ->got;
    end
  end

  always @(posedge host_done)
  begin
    got_word = host_word;
    ->got;
  end

  always @(got)
  begin
    check(expq.size() > 0, 1'b1);
    if (expq.size() > 0)
      check(got_word, expq.pop_front());
  end

  // Pin enables are compared at the rising edge, clear of the stimulus
  // that the main sequence changes at the falling one.
  always @(posedge core_clk)
  begin
    if (rstn)
    begin
      check(serial_out_oe, !chip_select_n);
      check(sclk_out_oe, port_role_select & !chip_select_n);
    end
  end

  always @(negedge core_clk)
  begin
    if (!rstn)
      act_n = 0;
    if (modulator_active === 1'b1)
      act_n++;
    else if (act_n != 0)
    begin
      check(act_n, 354);
      act_n = 0;
    end
  end

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    seed = 4153;
    fails = 0;
    n_checks = 0;
    m_cnt = 0;
    act_n = 0;
    tie = 1'b0;
    hold_sel = 1'b0;
    read_go = 1'b0;
    polarity_select = 1'b0;
    start_q = 1'b1;
    power_down_n = 1'b1;
    port_role_select = 1'b1;
    analog_code = $random(seed);
    do_reset;
    // Single conversion, master-clocked read of an offset-binary word.
    expq.push_back(analog_code);
    start_q = 1'b0;
    cyc(100);
    start_q = 1'b1;
    wait_rdy(1'b0, 1600);
    check(n + 100 >= 1600 && n + 100 <= 1604, 1'b1);
    hold_sel = 1'b1;
    wait_rdy(1'b1, 60);
    check(n <= 55, 1'b1);
    hold_sel = 1'b0;
    cyc(1700);
    check(data_ready_n, 1'b1);
    // Back-to-back conversions with boundary codes in two's complement.
    polarity_select = 1'b1;
    hold_sel = 1'b1;
    start_q = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      analog_code = codes[k % 4];
      expq.push_back(codes[k % 4] ^ 24'h800000);
      wait_rdy(1'b1, 60);
      t = n;
      wait_rdy(1'b0, 1700);
      if (k > 0)
        check(t + n, 1600);
      if (k == 3)
        start_q = 1'b1;
    end
    wait_rdy(1'b1, 60);
    // Ready fed back to start.
    polarity_select = 1'b0;
    analog_code = $random(seed);
    for (int k = 0; k < 5; k++)
      expq.push_back(analog_code);
    tie = 1'b1;
    start_q = 1'b0;
    cyc(5);
    start_q = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wait_rdy(1'b1, 60);
      t = n;
      wait_rdy(1'b0, 1700);
      if (k > 0)
        check(t + n, 1602);
    end
    wait_rdy(1'b1, 60);
    tie = 1'b0;
    wait_rdy(1'b0, 1700);
    wait_rdy(1'b1, 60);
    // Host-clocked read between conversions, after a second reset.
    hold_sel = 1'b0;
    port_role_select = 1'b0;
    do_reset;
    polarity_select = 1'b1;
    analog_code = $random(seed);
    expq.push_back(analog_code ^ 24'h800000);
    start_q = 1'b0;
    cyc(10);
    start_q = 1'b1;
    wait_rdy(1'b0, 1700);
    read_go = 1'b1;
    wait_rdy(1'b1, 300);
    check(n >= 200 && n <= 210, 1'b1);
    read_go = 1'b0;
    // Unread word with chip select low: early ready release.
    cyc(30);
    hold_sel = 1'b1;
    start_q = 1'b0;
    wait_rdy(1'b0, 1700);
    wait_rdy(1'b1, 1700);
    t = n;
    wait_rdy(1'b0, 60);
    check(t + n, 1600);
    check(n, 2);
    start_q = 1'b1;
    hold_sel = 1'b0;
    cyc(1700);
    // Power-down refuses starts, then wakes up. Reset stays high.
    power_down_n = 1'b0;
    start_q = 1'b0;
    cyc(5);
    check(data_ready_n, 1'b1);
    cyc(2000);
    check(data_ready_n, 1'b1);
    start_q = 1'b1;
    power_down_n = 1'b1;
    wait_rdy(1'b0, 3200);
    check(n >= 3083 && n <= 3088, 1'b1);
    cyc(20);
    check(expq.size(), 0);
    give_verdict;
  end
endmodule
